/* rtl/sfc_pkg.sv */
// How it works
// - Nonzero mode maps the FIFO status at address 0x00.
// - Status holds overflow bit 7, level mark bit 6, count bits 5..0.
// - Count reports samples held; zero is empty, up to 32.
// - Flags follow their cause; status read clears only the interrupt source.
// - Interrupt source sets again on next stored sample if a flag holds.
// - Overflow flag stays set while the FIFO is overflowed.
// - Level mark flag set while count is at or above threshold.
// - Trigger mode keeps overflow clear before the trigger event.
// - Trigger mode overflow set means storing has stopped.
// - Mode 00 off, 01 circular, 10 stop when full.
// - Trigger mode: circular, then 32 minus threshold more samples, stop.
// - Flush on disable, automatic rate change, standby to active.
// - Writing mode 00 clears flags and count.
// - Outside trigger mode, count reaching 32 asserts the overflow flag.
// - Threshold zero suppresses the level mark flag.
// - Trigger mode threshold sets retained pre-trigger samples.
// - Mode writable always; threshold writable only in standby.
// - Count above threshold never blocks storing.
// - Samples stored at active or sleep rate as selected.
// - Reading FIFO bytes returns oldest data; the last byte of a sample set pops it, count minus one.
// - Nonzero mode maps sample output from 0x01 to the FIFO head.
// - Interrupt source set on a stored sample while overflowed or count at or above threshold.
package sfc_pkg;
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_OUT_X_HI = 8'h01;
  localparam logic [7:0] ADDR_OUT_Z_LO = 8'h06;
  localparam logic [7:0] ADDR_CONFIG   = 8'h09;
  localparam int         DEPTH         = 32;
  localparam int         CNT_W         = 6;
  localparam int         AXIS_W        = 14;
  localparam int         BIT_OVF       = 7;
  localparam int         BIT_MARK      = 6;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [5:0] CNT_FULL      = 6'h20;

  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_CIRC = 2'h1,
    MODE_FILL = 2'h2,
    MODE_TRIG = 2'h3
  } sfc_mode_type;

  typedef struct packed {
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
  } sfc_sample_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfc_access_type;
endpackage : sfc_pkg

/* rtl/sfc_store.sv */
`timescale 1ns/1ps
module sfc_store
  import sfc_pkg::*;
#(
  parameter int DEPTH_P = DEPTH
) (
  input  wire logic           I_CLOCK,
  input  wire logic           I_RESET,
  // Control
  input  wire logic           i_flush,
  input  wire logic           i_push,
  input  wire logic           i_drop,
  input  wire logic           i_pop,
  // Data
  input  wire sfc_sample_type i_sample,
  output sfc_sample_type      o_head,
  output logic [CNT_W-1:0]    o_count
);
  localparam int AW = $clog2(DEPTH_P);

  sfc_sample_type       mem_reg [DEPTH_P];
  sfc_sample_type       mem_next[DEPTH_P];
  logic [AW-1:0]        rd_reg, rd_next, wr_reg, wr_next;
  logic [CNT_W-1:0]     cnt_reg, cnt_next;

  // Drop of the oldest happens together with push, count stays put
  always_comb begin
    for (int i = 0; i < DEPTH_P; i++) begin
      mem_next[i] = mem_reg[i];
    end
    rd_next  = rd_reg;
    wr_next  = wr_reg;
    cnt_next = cnt_reg;
    if (i_flush) begin
      rd_next  = '0;
      wr_next  = '0;
      cnt_next = '0;
    end else begin
      if (i_push) begin
        mem_next[wr_reg] = i_sample;
        wr_next          = AW'(wr_reg + 1'b1);
      end
      if (i_pop || i_drop) begin
        rd_next = AW'(rd_reg + 1'b1);
      end
      cnt_next = CNT_W'(cnt_reg + (i_push ? 1 : 0) - ((i_pop || i_drop) ? 1 : 0));
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
    for (int i = 0; i < DEPTH_P; i++) begin
      mem_reg[i] <= mem_next[i];
    end
  end

  assign o_head  = mem_reg[rd_reg];
  assign o_count = cnt_reg;
endmodule : sfc_store

/* rtl/sfc_top.sv */
`timescale 1ns/1ps
module sfc_top
  import sfc_pkg::*;
(
  input  wire logic           I_CLOCK,
  input  wire logic           I_RESET,
  // Register access from the serial bus engine
  input  wire sfc_access_type I_ACCESS,
  output logic [7:0]          O_RDATA,
  output logic                O_RVALID,
  // Sample stream at the system output data rate
  input  wire logic           I_SAMPLE_STROBE,
  input  wire sfc_sample_type I_SAMPLE,
  input  wire logic [7:0]     I_DATA_STATUS,
  // System state
  input  wire logic           I_ACTIVE,
  input  wire logic           I_RATE_CHANGE,
  input  wire logic           I_TRIGGER,
  // Status
  output logic                O_FIFO_INT_SOURCE,
  output logic [7:0]          O_CONFIG
);
  logic [1:0]       mode_reg, mode_next;
  logic [5:0]       thr_reg, thr_next;
  logic             ovf_reg, ovf_next;
  logic             trig_reg, trig_next;
  logic [5:0]       post_reg, post_next;
  logic             src_reg, src_next;
  logic             act_reg, act_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic             rvalid_reg, rvalid_next;
  logic [2:0]       byte_reg, byte_next;
  sfc_sample_type   cur_reg, cur_next;
  logic             flush, push, drop, pop, mark, full, stopped;
  sfc_sample_type   head;
  logic [CNT_W-1:0] count;

  function automatic logic [7:0] pick_byte(sfc_sample_type s,
                                           logic [2:0] idx);
    logic [AXIS_W-1:0] w;
    w = (idx < 3'h2) ? s.x : ((idx < 3'h4) ? s.y : s.z);
    pick_byte = idx[0] ? {w[5:0], 2'h0} : w[13:6];
  endfunction : pick_byte

  sfc_store #(.DEPTH_P(DEPTH)) u_store (
    .I_CLOCK (I_CLOCK),
    .I_RESET (I_RESET),
    .i_flush (flush),
    .i_push  (push),
    .i_drop  (drop),
    .i_pop   (pop),
    .i_sample(I_SAMPLE),
    .o_head  (head),
    .o_count (count)
  );

  wire cfg_wr  = I_ACCESS.wr && (I_ACCESS.addr == ADDR_CONFIG);
  wire mode_on = (mode_reg != MODE_OFF);
  wire out_rd  = I_ACCESS.rd && (I_ACCESS.addr >= ADDR_OUT_X_HI) &&
                 (I_ACCESS.addr <= ADDR_OUT_Z_LO);
  wire stat_rd = I_ACCESS.rd && (I_ACCESS.addr == ADDR_STATUS) && mode_on;

  assign full = (count == CNT_FULL);
  // Trigger mode stops after the post-trigger budget runs out; until then
  // a full buffer keeps dropping its oldest, so thr pre-trigger sets remain
  assign stopped = (mode_reg == MODE_FILL && full) ||
                   (mode_reg == MODE_TRIG && trig_reg &&
                    post_reg == 6'h00);
  assign mark  = (thr_reg != 6'h00) && (count >= thr_reg);
  // Flush on disable, rate change and the standby-to-active edge
  assign flush = (cfg_wr && I_ACCESS.wdata[7:6] == MODE_OFF) ||
                 I_RATE_CHANGE || (I_ACTIVE && !act_reg) ||
                 !mode_on;
  // Storing runs at whatever rate the strobe already reflects
  assign push = I_SAMPLE_STROBE && mode_on && !stopped;
  assign drop = push && full;
  // Last byte of a sample set pops it
  assign pop  = out_rd && mode_on && (byte_reg == 3'h5) &&
                (count != 0) && !drop;

  always_comb begin
    act_next  = I_ACTIVE;
    mode_next = mode_reg;
    thr_next  = thr_reg;
    if (cfg_wr) begin
      mode_next = I_ACCESS.wdata[7:6];
      if (!I_ACTIVE) begin
        thr_next = I_ACCESS.wdata[5:0];
      end
    end
  end

  always_comb begin
    ovf_next  = ovf_reg;
    trig_next = trig_reg;
    post_next = post_reg;
    if (flush) begin
      ovf_next  = 1'b0;
      trig_next = 1'b0;
      post_next = 6'h00;
    end else begin
      if (mode_reg == MODE_TRIG) begin
        if (I_TRIGGER && !trig_reg) begin
          trig_next = 1'b1;
          post_next = CNT_W'(CNT_FULL - thr_reg);
        end else if (trig_reg && push && post_reg != 6'h00) begin
          post_next = post_reg - 6'h01;
        end
        // Overflow only once storing has stopped after the trigger
        ovf_next = trig_reg && stopped;
      end else begin
        ovf_next = full;
      end
    end
  end

  // Set wins over the status-read clear
  always_comb begin
    src_next = src_reg;
    if (stat_rd) begin
      src_next = 1'b0;
    end
    if (flush) begin
      src_next = 1'b0;
    end else if (push && (full || ovf_reg ||
             (thr_reg != 0 && CNT_W'(count + 1'b1) >= thr_reg))) begin
      src_next = 1'b1;
    end
  end

  always_comb begin
    cur_next = cur_reg;
    if (I_SAMPLE_STROBE) begin
      cur_next = I_SAMPLE;
    end
    byte_next = byte_reg;
    if (out_rd) begin
      byte_next = (byte_reg == 3'h5) ? 3'h0 :
                  3'(I_ACCESS.addr - ADDR_OUT_X_HI + 1'b1);
    end
    rvalid_next = I_ACCESS.rd;
    rdata_next = rdata_reg;
    if (I_ACCESS.rd) begin
      unique case (I_ACCESS.addr)
        ADDR_STATUS: rdata_next = mode_on ?
          {ovf_reg, mark, count} : I_DATA_STATUS;
        ADDR_CONFIG: rdata_next = {mode_reg, thr_reg};
        default: begin
          if (out_rd) begin
            rdata_next = mode_on ?
              pick_byte(head, byte_reg) :
              pick_byte(cur_reg, 3'(I_ACCESS.addr - ADDR_OUT_X_HI));
          end else begin
            rdata_next = 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      mode_reg <= CONFIG_RESET[7:6];
      thr_reg  <= CONFIG_RESET[5:0];
      act_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      thr_reg  <= thr_next;
      act_reg  <= act_next;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ovf_reg  <= 1'b0;
      trig_reg <= 1'b0;
      post_reg <= 6'h00;
    end else begin
      ovf_reg  <= ovf_next;
      trig_reg <= trig_next;
      post_reg <= post_next;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      src_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      byte_reg   <= 3'h0;
      cur_reg    <= '0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      byte_reg   <= byte_next;
      cur_reg    <= cur_next;
    end
  end

  assign O_RDATA           = rdata_reg;
  assign O_RVALID          = rvalid_reg;
  assign O_FIFO_INT_SOURCE = src_reg;
  assign O_CONFIG          = {mode_reg, thr_reg};
endmodule : sfc_top

/* dv/sfc_properties.sv */
`timescale 1ns/1ps
module sfc_checker
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic           I_CLOCK,
  input wire logic           I_RESET,
  // Register access
  input wire sfc_access_type I_ACCESS,
  input wire logic [7:0]     O_RDATA,
  input wire logic           O_RVALID,
  // Samples, state and status
  input wire logic           I_SAMPLE_STROBE,
  input wire logic [7:0]     I_DATA_STATUS,
  input wire logic           I_ACTIVE,
  input wire logic           O_FIFO_INT_SOURCE,
  input wire logic [7:0]     O_CONFIG
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  sequence s_cfg_wr;
    I_ACCESS.wr && I_ACCESS.addr == ADDR_CONFIG;
  endsequence
  sequence s_stat_rd;
    I_ACCESS.rd && I_ACCESS.addr == ADDR_STATUS;
  endsequence
  property p_answer;
    I_ACCESS.rd |=> O_RVALID;
  endproperty
  property p_cfg_standby;
    s_cfg_wr ##0 !I_ACTIVE |=> O_CONFIG == $past(I_ACCESS.wdata);
  endproperty
  property p_thr_locked;
    s_cfg_wr ##0 I_ACTIVE |=>
      O_CONFIG == {$past(I_ACCESS.wdata[7:6]), $past(O_CONFIG[5:0])};
  endproperty
  property p_plain_status;
    s_stat_rd ##0 O_CONFIG[7:6] == 2'h0 |=> O_RDATA == $past(I_DATA_STATUS);
  endproperty
  // Trigger mode reports the same level mark bit but is left out of this check
  property p_mark;
    s_stat_rd ##0 O_CONFIG[7:6] inside {2'h1, 2'h2} |=>
      O_RDATA[5:0] <= CNT_FULL && O_RDATA[BIT_MARK] ==
      ($past(O_CONFIG[5:0]) != 6'h00 && O_RDATA[5:0] >= $past(O_CONFIG[5:0]));
  endproperty
  property p_int_rise;
    $rose(O_FIFO_INT_SOURCE) |-> $past(I_SAMPLE_STROBE);
  endproperty
  property p_disable_clears;
    s_cfg_wr ##0 I_ACCESS.wdata[7:6] == 2'h0 |=> !O_FIFO_INT_SOURCE;
  endproperty
  property p_read_clears;
    s_stat_rd ##0 O_CONFIG[7:6] != 2'h0 && !I_SAMPLE_STROBE
      |=> !O_FIFO_INT_SOURCE;
  endproperty
  a_answer: assert property (p_answer) else $error("no read answer");
  a_cfg_standby: assert property (p_cfg_standby)
    else $error("cfg write");
  a_thr_locked: assert property (p_thr_locked)
    else $error("thr locked");
  a_plain_status: assert property (p_plain_status)
    else $error("status");
  a_mark: assert property (p_mark)
    else $error("mark flag or count");
  a_int_rise: assert property (p_int_rise)
    else $error("int rise");
  a_disable_clears: assert property (p_disable_clears)
    else $error("off");
  a_read_clears: assert property (p_read_clears)
    else $error("int clr");
endmodule : sfc_checker

bind sfc_top sfc_checker u_chk (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_ACCESS(I_ACCESS),
  .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_SAMPLE_STROBE(I_SAMPLE_STROBE),
  .I_DATA_STATUS(I_DATA_STATUS), .I_ACTIVE(I_ACTIVE),
  .O_FIFO_INT_SOURCE(O_FIFO_INT_SOURCE), .O_CONFIG(O_CONFIG)
);

/* dv/sfc_host.sv */
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
(
  // Register bus
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output sfc_access_type  o_access
);
  logic ok;
  initial o_access = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_access <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clock);
    o_access <= '0;
  endtask : wr
  // Chained by the bench into bursts over the data bytes
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_access <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_access <= '0;
    // Taken off the edge, while the one-cycle answer stands
    @(negedge i_clock);
    ok = i_rvalid;
    d = i_rdata;
  endtask : rd
endmodule : sfc_host

/* dv/sfc_top_tb.sv */
`timescale 1ns/1ps
module sfc_top_tb;
  import sfc_pkg::*;
  logic           clk, rst, strobe, active, rate_chg, trig, rvalid, int_src;
  logic [7:0]     rdata, cfg, d;
  sfc_access_type acc;
  sfc_sample_type smp;
  int             err_count, n_compared;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sfc_host h (.i_clock(clk), .i_rdata(rdata), .i_rvalid(rvalid),
              .o_access(acc));
  sfc_top DUT (.I_CLOCK(clk), .I_RESET(rst), .I_ACCESS(acc), .O_RDATA(rdata),
    .O_RVALID(rvalid), .I_SAMPLE_STROBE(strobe), .I_SAMPLE(smp),
    .I_DATA_STATUS(8'h5a), .I_ACTIVE(active), .I_RATE_CHANGE(rate_chg),
    .I_TRIGGER(trig), .O_FIFO_INT_SOURCE(int_src), .O_CONFIG(cfg));
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic sfc_sample_type mk(input int k);
    return '{x: 14'(k * 5 + 1), y: 14'(k + 2), z: 14'(k * 3)};
  endfunction : mk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    chk("rvalid", 8'h01, {7'h00, h.ok});
    chk($sformatf("reg %h", a), e, d);
  endtask : rdc
  // Ends off the edge so outputs of the last push have settled
  task automatic push(input int first, input int n);
    for (int k = first; k < first + n; k++) begin
      @(posedge clk);
      smp <= mk(k);
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
    end
    @(negedge clk);
  endtask : push
  task automatic head(input int k);
    logic [13:0]    v;
    sfc_sample_type s;
    s = mk(k);
    for (int i = 0; i < 3; i++) begin
      v = s[41-14*i -: 14];
      rdc(8'(1 + 2 * i), v[13:6]);
      rdc(8'(2 + 2 * i), {v[5:0], 2'h0});
    end
  endtask : head
  task automatic t_regs;
    rdc(ADDR_CONFIG, CONFIG_RESET);
    rdc(ADDR_STATUS, 8'h5a);
    rdc(8'h20, 8'h00);
    h.wr(ADDR_CONFIG, 8'h45);
    rdc(ADDR_CONFIG, 8'h45);
    @(posedge clk);
    active <= 1'b1;
    h.wr(ADDR_CONFIG, 8'h00);
    h.wr(ADDR_CONFIG, 8'h8a);
    rdc(ADDR_CONFIG, 8'h85);
    chk("config pins", 8'h85, cfg);
    $display("regs done");
  endtask : t_regs
  task automatic t_fill;
    push(0, 33);
    chk("int", 8'h01, {7'h00, int_src});
    rdc(ADDR_STATUS, 8'he0);
    chk("int", 8'h00, {7'h00, int_src});
    rdc(ADDR_STATUS, 8'he0);
    head(0);
    rdc(ADDR_STATUS, 8'h5f);
    push(100, 1);
    chk("int", 8'h01, {7'h00, int_src});
    $display("fill done");
  endtask : t_fill
  task automatic t_circ;
    h.wr(ADDR_CONFIG, 8'h00);
    rdc(ADDR_STATUS, 8'h5a);
    chk("int", 8'h00, {7'h00, int_src});
    h.wr(ADDR_CONFIG, 8'h40);
    rdc(ADDR_STATUS, 8'h00);
    push(0, 34);
    rdc(ADDR_STATUS, 8'he0);
    head(2);
    $display("circ done");
  endtask : t_circ
  task automatic t_trig;
    h.wr(ADDR_CONFIG, 8'h00);
    h.wr(ADDR_CONFIG, 8'hc5);
    push(0, 40);
    h.rd(ADDR_STATUS, d);
    chk("ovf", 8'h00, {7'h00, d[BIT_OVF]});
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    push(40, 40);
    rdc(ADDR_STATUS, 8'he0);
    head(35);
    $display("trig done");
  endtask : t_trig
  task automatic t_flush;
    @(posedge clk);
    rate_chg <= 1'b1;
    @(posedge clk);
    rate_chg <= 1'b0;
    rdc(ADDR_STATUS, 8'h00);
    push(0, 3);
    rdc(ADDR_STATUS, 8'h03);
    @(posedge clk);
    active <= 1'b0;
    @(posedge clk);
    active <= 1'b1;
    rdc(ADDR_STATUS, 8'h00);
    $display("flush done");
  endtask : t_flush
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    {rst, strobe, active, rate_chg, trig} = 5'h10;
    smp = '0;
    err_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fill();
    t_circ();
    t_trig();
    t_flush();
    print_verdict();
  end
endmodule : sfc_top_tb
